/* hdl/tcc_pkg.sv */
// Constants and carrier types for the timer0 capture/compare register block
package tcc_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // I/O offsets
    localparam logic [5:0] OFS_CONTROL_A = 6'h15;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h39;
    localparam logic [5:0] OFS_COUNTER_LOW = 6'h12;
    localparam logic [5:0] OFS_COUNTER_HIGH = 6'h14;
    localparam logic [5:0] OFS_COMPARE_A = 6'h13;
    localparam logic [5:0] OFS_COMPARE_B = 6'h11;

    // Control register fields
    localparam int CTL_WIDTH_SELECT = 7;
    localparam int CTL_CAPTURE_MODE = 6;
    localparam int CTL_FILTER_ENABLE = 5;
    localparam int CTL_EDGE_SELECT = 4;
    localparam int CTL_COMPARATOR_ROUTE = 3;
    localparam int CTL_COUNT_SEQUENCE = 0;
    localparam logic [7:0] CTL_WRITE_MASK = 8'hF9;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Interrupt mask fields
    localparam int MSK_COMPARE_A = 4;
    localparam int MSK_COMPARE_B = 3;
    localparam int MSK_OVERFLOW = 1;
    localparam int MSK_CAPTURE = 0;
    localparam logic [7:0] MSK_RESET = 8'h00;

    // Flag vector positions
    localparam int FLG_CAPTURE = 0;
    localparam int FLG_OVERFLOW = 1;
    localparam int FLG_COMPARE_B = 2;
    localparam int FLG_COMPARE_A = 3;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam int FILTER_SAMPLES = 4;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tcc_bus_req_t;

    typedef struct packed {
        logic compare_a;
        logic compare_b;
        logic overflow;
        logic capture;
    } tcc_events_t;

endpackage

/* hdl/tcc_capture_front.sv */
// Capture front end: pin synchroniser, source select, noise filter, edge detect
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_front (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic capture_pin_i,
    input wire logic comparator_i,
    input wire logic route_i,
    input wire logic filter_en_i,
    input wire logic edge_sel_i,
    output logic capture_o
);
    logic [1:0] pin_sync;
    logic [1:0] cmp_sync;
    logic [tcc_pkg::FILTER_SAMPLES-1:0] hist;
    logic filt;
    logic prev;
    logic sel;
    logic [tcc_pkg::FILTER_SAMPLES-1:0] next_hist;
    logic next_filt;
    logic src;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Comparator is fully disconnected unless routed in
        src = route_i ? cmp_sync[1] : pin_sync[1];
        next_hist = {hist[tcc_pkg::FILTER_SAMPLES-2:0], src};
        next_filt = filt;
        if (&next_hist) begin
            next_filt = 1'b1;
        end else if (~|next_hist) begin
            next_filt = 1'b0;
        end
        // Filter path costs four extra clocks of latency
        sel = filter_en_i ? filt : src;
        capture_o = (sel != prev) && (sel == edge_sel_i);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            pin_sync <= 2'h0;
            cmp_sync <= 2'h0;
            hist <= '0;
            filt <= 1'b0;
            prev <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[0], capture_pin_i};
            cmp_sync <= {cmp_sync[0], comparator_i};
            hist <= next_hist;
            filt <= next_filt;
            prev <= sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    filter_agree_a: assert property ($changed(filt) |-> (&hist) || (~|hist))
        else $error("filter output moved without four equal samples");
    edge_polarity_a: assert property (capture_o |-> sel == edge_sel_i && $past(sel) != edge_sel_i)
        else $error("capture on wrong edge");
endmodule
`default_nettype wire

/* hdl/tcc_regs.sv */
// Timer0 register interface with counter, compare, capture and flag logic
//
// Summary of operation
// - Shared high-byte holder keeps its value after a low-byte write.
// - Width bit 7 makes counter 16 bits and joins both compare registers.
// - Control bit 6 enables capture mode.
// - Control bit 5 filters capture input: four equal samples needed to change.
// - Control bit 4 picks capture edge: zero falling, one rising.
// - Capture edge copies counter into capture register and sets capture flag.
// - Control bit 3 routes comparator into capture front end, else disconnected.
// - Control bits 2 and 1 ignore writes and read zero.
// - Control bit 0 selects normal or clear-on-match counting.
// - Counter low byte is read/write; a write blocks match on next tick.
// - In 16-bit mode counter bytes pass through one shared high-byte holder.
// - Compare A compares with counter low byte; low byte of 16-bit compare.
// - Compare B compares low byte in 8-bit mode; high byte via holder in 16.
// - Mask bit 4 enables compare A request with global enable and flag.
// - Mask bit 3 enables compare B request with global enable and flag.
// - Mask bit 1 enables overflow request with global enable and flag.
// - Mask bit 0 enables capture request with global enable and flag.
// - Low write loads high byte from holder and low byte together; low read copies upper into holder.
// - Compare mode reads bypass holder; 16-bit capture reads go through it.
// - Equality sets compare flag on next tick; only flag A in 16-bit mode.
`timescale 1ns/1ps
`default_nettype none
module tcc_regs (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire tcc_pkg::tcc_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic timer_tick_i,
    input wire logic global_irq_enable_i,
    input wire tcc_pkg::tcc_events_t flag_clear_i,
    input wire logic capture_pin_i,
    input wire logic comparator_i,
    output tcc_pkg::tcc_events_t flags_o,
    output tcc_pkg::tcc_events_t irq_req_o,
    output logic [3:0] other_timer_mask_o,
    output logic [15:0] counter_o
);
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic block;
    logic pend_a;
    logic pend_b;
    tcc_pkg::tcc_events_t flags;

    logic [7:0] next_ctrl;
    logic [7:0] next_mask;
    logic [7:0] next_cnt_lo;
    logic [7:0] next_cnt_hi;
    logic [7:0] next_cmp_a;
    logic [7:0] next_cmp_b;
    logic [7:0] next_temp;
    logic [7:0] next_rdata;
    logic next_block;
    logic next_pend_a;
    logic next_pend_b;
    tcc_pkg::tcc_events_t next_flags;
    tcc_pkg::tcc_events_t set;

    logic wide;
    logic cap_mode;
    logic clear_on_match_counting;
    logic cap_evt;
    logic eq_a;
    logic eq_b;
    logic at_max;
    logic wr_cnt;

    function automatic logic hit(input tcc_pkg::tcc_bus_req_t b, input logic strobe, input logic [5:0] ofs);
        hit = strobe && (b.addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    tcc_capture_front u_front (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .capture_pin_i(capture_pin_i),
        .comparator_i(comparator_i),
        .route_i(ctrl[tcc_pkg::CTL_COMPARATOR_ROUTE]),
        .filter_en_i(ctrl[tcc_pkg::CTL_FILTER_ENABLE]),
        .edge_sel_i(ctrl[tcc_pkg::CTL_EDGE_SELECT]),
        .capture_o(cap_evt)
    );

    assign wide = ctrl[tcc_pkg::CTL_WIDTH_SELECT];
    assign cap_mode = ctrl[tcc_pkg::CTL_CAPTURE_MODE];
    assign clear_on_match_counting = ctrl[tcc_pkg::CTL_COUNT_SEQUENCE];
    assign wr_cnt = hit(bus_i, bus_i.wr, tcc_pkg::OFS_COUNTER_LOW) || hit(bus_i, bus_i.wr, tcc_pkg::OFS_COUNTER_HIGH);

    always_comb begin
        // Joined compare value in wide mode, low-byte compare otherwise
        eq_a = wide ? ({cnt_hi, cnt_lo} == {cmp_b, cmp_a}) : (cnt_lo == cmp_a);
        eq_b = !wide && (cnt_lo == cmp_b);
        at_max = (cnt_lo == tcc_pkg::BYTE_MAX) && (!wide || cnt_hi == tcc_pkg::BYTE_MAX);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_ctrl = ctrl;
        next_mask = mask;
        next_cnt_lo = cnt_lo;
        next_cnt_hi = cnt_hi;
        next_cmp_a = cmp_a;
        next_cmp_b = cmp_b;
        next_temp = temp;
        next_rdata = rdata;
        next_block = block;
        next_pend_a = pend_a;
        next_pend_b = pend_b;
        set = '0;

        // Counting core, advanced by the prescaler enable
        if (timer_tick_i) begin
            if (clear_on_match_counting && !cap_mode && eq_a) begin
                next_cnt_lo = tcc_pkg::BYTE_ZERO;
                next_cnt_hi = tcc_pkg::BYTE_ZERO;
            end else begin
                next_cnt_lo = cnt_lo + tcc_pkg::BYTE_ONE;
                if (wide && cnt_lo == tcc_pkg::BYTE_MAX) begin
                    next_cnt_hi = cnt_hi + tcc_pkg::BYTE_ONE;
                end
                set.overflow = at_max;
            end
            // Flag rises one tick after the equality was seen
            set.compare_a = pend_a;
            // A match left pending from 8-bit mode must not flag B once the pair is joined
            set.compare_b = pend_b && !wide;
            next_pend_a = eq_a && !block && !cap_mode;
            next_pend_b = eq_b && !block && !cap_mode;
            next_block = 1'b0;
        end

        // Capture snapshot, counter low byte lands in compare A, high byte in compare B only when wide
        if (cap_evt && cap_mode) begin
            next_cmp_a = cnt_lo;
            if (wide) begin
                next_cmp_b = cnt_hi;
            end
            set.capture = 1'b1;
        end

        // Processor writes
        if (bus_i.wr) begin
            case (bus_i.addr)
                tcc_pkg::OFS_CONTROL_A: next_ctrl = bus_i.wdata & tcc_pkg::CTL_WRITE_MASK;
                tcc_pkg::OFS_IRQ_MASK: next_mask = bus_i.wdata;
                tcc_pkg::OFS_COUNTER_LOW: begin
                    next_cnt_lo = bus_i.wdata;
                    // Holder is left intact so one high byte serves several writes
                    if (wide) begin
                        next_cnt_hi = temp;
                    end
                    next_block = 1'b1;
                end
                tcc_pkg::OFS_COUNTER_HIGH: begin
                    if (wide) begin
                        next_temp = bus_i.wdata;
                    end else begin
                        next_cnt_hi = bus_i.wdata;
                    end
                    next_block = 1'b1;
                end
                tcc_pkg::OFS_COMPARE_A: begin
                    if (!(cap_evt && cap_mode)) begin
                        next_cmp_a = bus_i.wdata;
                        if (wide) begin
                            next_cmp_b = temp;
                        end
                    end
                end
                tcc_pkg::OFS_COMPARE_B: begin
                    if (wide) begin
                        next_temp = bus_i.wdata;
                    end else if (!(cap_evt && cap_mode)) begin
                        next_cmp_b = bus_i.wdata;
                    end
                end
                default: next_temp = temp;
            endcase
        end

        // Processor reads, with holder side effects
        if (bus_i.rd) begin
            case (bus_i.addr)
                tcc_pkg::OFS_CONTROL_A: next_rdata = ctrl;
                tcc_pkg::OFS_IRQ_MASK: next_rdata = mask;
                tcc_pkg::OFS_COUNTER_LOW: begin
                    next_rdata = cnt_lo;
                    if (wide) begin
                        next_temp = cnt_hi;
                    end
                end
                tcc_pkg::OFS_COUNTER_HIGH: next_rdata = wide ? temp : cnt_hi;
                tcc_pkg::OFS_COMPARE_A: begin
                    next_rdata = cmp_a;
                    if (wide && cap_mode) begin
                        next_temp = cmp_b;
                    end
                end
                // Compare mode bypasses the holder: the value only moves on writes
                tcc_pkg::OFS_COMPARE_B: next_rdata = (wide && cap_mode) ? temp : cmp_b;
                default: next_rdata = tcc_pkg::BYTE_ZERO;
            endcase
        end

        // Set wins over clear in the same cycle
        next_flags = (flags & ~flag_clear_i) | set;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctrl <= tcc_pkg::CTL_RESET;
            mask <= tcc_pkg::MSK_RESET;
            cnt_lo <= tcc_pkg::BYTE_ZERO;
            cnt_hi <= tcc_pkg::BYTE_ZERO;
            cmp_a <= tcc_pkg::BYTE_ZERO;
            cmp_b <= tcc_pkg::BYTE_ZERO;
            temp <= tcc_pkg::BYTE_ZERO;
            rdata <= tcc_pkg::BYTE_ZERO;
            block <= 1'b0;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
            flags <= '0;
        end else begin
            ctrl <= next_ctrl;
            mask <= next_mask;
            cnt_lo <= next_cnt_lo;
            cnt_hi <= next_cnt_hi;
            cmp_a <= next_cmp_a;
            cmp_b <= next_cmp_b;
            temp <= next_temp;
            rdata <= next_rdata;
            block <= next_block;
            pend_a <= next_pend_a;
            pend_b <= next_pend_b;
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Handlers sharing the holder must mask interrupts; no hardware guard
    assign rdata_o = rdata;
    assign flags_o = flags;
    assign counter_o = {cnt_hi, cnt_lo};
    assign other_timer_mask_o = {mask[7:5], mask[2]};
    assign irq_req_o.compare_a = flags.compare_a && mask[tcc_pkg::MSK_COMPARE_A] && global_irq_enable_i;
    assign irq_req_o.compare_b = flags.compare_b && mask[tcc_pkg::MSK_COMPARE_B] && global_irq_enable_i;
    assign irq_req_o.overflow = flags.overflow && mask[tcc_pkg::MSK_OVERFLOW] && global_irq_enable_i;
    assign irq_req_o.capture = flags.capture && mask[tcc_pkg::MSK_CAPTURE] && global_irq_enable_i;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence low_write_s;
        wide && hit(bus_i, bus_i.wr, tcc_pkg::OFS_COUNTER_LOW) && !timer_tick_i;
    endsequence
    sequence blocked_tick_s;
        wr_cnt ##1 (timer_tick_i && eq_a && !wr_cnt);
    endsequence
    sequence match_seen_s;
        timer_tick_i && eq_a && !block && !cap_mode;
    endsequence

    reserved_zero_a: assert property (ctrl[2:1] == 2'h0)
        else $error("reserved control bits not zero");
    low_write_load_a: assert property (low_write_s |=> {cnt_hi, cnt_lo} == {$past(temp), $past(bus_i.wdata)})
        else $error("low write did not load both counter bytes");
    holder_kept_a: assert property (low_write_s |=> temp == $past(temp))
        else $error("holder changed by low write");
    low_read_copy_a: assert property (wide && hit(bus_i, bus_i.rd, tcc_pkg::OFS_COUNTER_LOW) && !bus_i.wr
        |=> temp == $past(cnt_hi) && rdata_o == $past(cnt_lo))
        else $error("low read did not copy high byte");
    capture_copy_a: assert property (cap_evt && cap_mode && !bus_i.wr |=> cmp_a == $past(cnt_lo) && flags.capture)
        else $error("capture did not copy counter");
    match_block_a: assert property (blocked_tick_s |=> !pend_a ##1 !set.compare_a[*1])
        else $error("match not blocked after counter write");
    wide_no_b_a: assert property (wide && timer_tick_i |=> !$rose(flags.compare_b))
        else $error("compare B flag set in 16-bit mode");
    match_delay_a: assert property (match_seen_s |=> pend_a)
        else $error("compare A match not held for the next tick");
    pend_flag_a: assert property (pend_a && timer_tick_i |=> flags.compare_a)
        else $error("compare A flag not set on next tick");
    ctc_clear_a: assert property (timer_tick_i && clear_on_match_counting && !cap_mode && eq_a && !bus_i.wr |=> counter_o == 16'h0000)
        else $error("clear on match failed");
    cmp_read_bypass_a: assert property (wide && !cap_mode && hit(bus_i, bus_i.rd, tcc_pkg::OFS_COMPARE_B)
        |=> rdata_o == $past(cmp_b))
        else $error("compare read went through holder");
    irq_gate_a: assert property (irq_req_o.compare_a |-> flags.compare_a && mask[tcc_pkg::MSK_COMPARE_A]
        && global_irq_enable_i)
        else $error("compare A request without enable");
    ovf_irq_a: assert property ($rose(flags.overflow) && mask[tcc_pkg::MSK_OVERFLOW] && global_irq_enable_i
        |-> irq_req_o.overflow)
        else $error("overflow request missing");
endmodule
`default_nettype wire

/* bench/tcc_cpu_model.sv */
// Processor-side bus model that drives the timer0 register block
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    output tcc_pkg::tcc_bus_req_t bus_o,
    output logic irq_en_o
);
    initial begin
        bus_o = '0;
        irq_en_o = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus shows inverted data so a stale value never looks like a fresh one
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_i);
        bus_o <= {wr, ~wr, a, d};
        @(posedge ref_clk_i);
        bus_o <= {2'b00, a, ~d};
        #1 q = rdata_i;
    endtask
    task automatic glob(input logic e);
        @(posedge ref_clk_i);
        irq_en_o <= e;
    endtask
    // Interrupts are held off so no handler can disturb the shared holder
    task automatic wr16(input logic [5:0] hi, input logic [5:0] lo, input logic [15:0] d);
        logic [7:0] q;
        glob(1'b0);
        access(1'b1, hi, d[15:8], q);
        access(1'b1, lo, d[7:0], q);
        glob(1'b1);
    endtask
    task automatic rd16(input logic [5:0] hi, input logic [5:0] lo, output logic [15:0] v);
        glob(1'b0);
        access(1'b0, lo, 8'h00, v[7:0]);
        access(1'b0, hi, 8'h00, v[15:8]);
        glob(1'b1);
    endtask
endmodule
`default_nettype wire

/* bench/tcc_regs_test.sv */
// Self-checking bench for the timer0 capture/compare register block
`timescale 1ns/1ps
`default_nettype none
module tcc_regs_test;
    logic ref_clk_i, reset_n_i, tick, pin, comp, glob;
    tcc_pkg::tcc_bus_req_t bus;
    tcc_pkg::tcc_events_t clr, flags, irq;
    logic [7:0] rdata, r, m, h, l, c;
    logic [3:0] other;
    logic [15:0] cnt, v;
    logic [31:0] seed;
    int failures, comparisons;

    tcc_cpu_model u_tcc_cpu_model (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .bus_o(bus), .irq_en_o(glob));
    tcc_regs u_tcc_regs (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus_i(bus), .rdata_o(rdata),
        .timer_tick_i(tick), .global_irq_enable_i(glob), .flag_clear_i(clr), .capture_pin_i(pin),
        .comparator_i(comp), .flags_o(flags), .irq_req_o(irq), .other_timer_mask_o(other), .counter_o(cnt));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        u_tcc_cpu_model.access(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [5:0] a);
        u_tcc_cpu_model.access(1'b0, a, 8'h00, r);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk_i) tick <= 1'b1;
            @(posedge ref_clk_i) tick <= 1'b0;
        end
        #1;
    endtask
    task automatic clear_flags();
        @(posedge ref_clk_i) clr <= '1;
        @(posedge ref_clk_i) clr <= '0;
        #1;
    endtask
    task automatic print_verdict();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    // Whole run is a few hundred cycles; this bound only catches a hang
    initial begin
        cyc(20000);
        failures++;
        print_verdict();
    end
    initial begin
        tick = 1'b0;
        pin = 1'b0;
        comp = 1'b0;
        clr = '0;
        reset_n_i = 1'b0;
        seed = 32'h0000D99C;
        failures = 0;
        comparisons = 0;
        cyc(12);
        reset_n_i <= 1'b1;
        rd(tcc_pkg::OFS_CONTROL_A);
        chk(r, tcc_pkg::CTL_RESET, "control reset");
        rd(tcc_pkg::OFS_IRQ_MASK);
        chk(r, tcc_pkg::MSK_RESET, "mask reset");
        wr(tcc_pkg::OFS_CONTROL_A, 8'hFF);
        rd(tcc_pkg::OFS_CONTROL_A);
        chk(r, 8'hF9, "reserved control bits");
        m = rnd();
        wr(tcc_pkg::OFS_IRQ_MASK, m);
        rd(tcc_pkg::OFS_IRQ_MASK);
        chk(r, m, "mask readback");
        chk(other, {m[7], m[6], m[5], m[2]}, "other timer mask");
        wr(tcc_pkg::OFS_IRQ_MASK, 8'h1B);
        // Overflow, then both 8-bit compare matches, then gating of requests
        wr(tcc_pkg::OFS_CONTROL_A, 8'h00);
        wr(tcc_pkg::OFS_COUNTER_LOW, 8'hFF);
        clear_flags();
        ticks(1);
        chk(flags, 4'b0010, "overflow flag");
        chk(irq, 4'b0010, "overflow request");
        // Equality at 0x0F and 0x10 flags on the following ticks, within four ticks from 0x0E
        wr(tcc_pkg::OFS_COMPARE_A, 8'h0F);
        wr(tcc_pkg::OFS_COMPARE_B, 8'h10);
        wr(tcc_pkg::OFS_COUNTER_LOW, 8'h0E);
        clear_flags();
        ticks(4);
        chk(flags, 4'b1100, "8-bit compare flags");
        chk(cnt[7:0], 8'h12, "counter advance");
        chk(irq, 4'b1100, "compare requests");
        u_tcc_cpu_model.glob(1'b0);
        #1 chk(irq, 4'b0000, "global enable off");
        u_tcc_cpu_model.glob(1'b1);
        // Counter written to the compare value must not match on the next tick
        wr(tcc_pkg::OFS_COMPARE_A, 8'h20);
        wr(tcc_pkg::OFS_COMPARE_B, 8'h20);
        wr(tcc_pkg::OFS_COUNTER_LOW, 8'h20);
        clear_flags();
        ticks(2);
        chk(flags, 4'b0000, "match blocked");
        wr(tcc_pkg::OFS_CONTROL_A, 8'h01);
        wr(tcc_pkg::OFS_COMPARE_A, 8'h05);
        wr(tcc_pkg::OFS_COUNTER_LOW, 8'h03);
        ticks(3);
        chk(cnt[7:0], 8'h00, "clear on match");
        // Wide mode through the shared holder
        wr(tcc_pkg::OFS_CONTROL_A, 8'h80);
        h = rnd();
        l = rnd();
        l[7] = 1'b0;
        l[4] = 1'b1;
        u_tcc_cpu_model.wr16(tcc_pkg::OFS_COUNTER_HIGH, tcc_pkg::OFS_COUNTER_LOW, {h, l});
        chk(cnt, {h, l}, "16-bit counter write");
        u_tcc_cpu_model.rd16(tcc_pkg::OFS_COUNTER_HIGH, tcc_pkg::OFS_COUNTER_LOW, v);
        chk(v, {h, l}, "16-bit counter read");
        wr(tcc_pkg::OFS_COMPARE_B, h);
        wr(tcc_pkg::OFS_COMPARE_A, l + 8'h02);
        wr(tcc_pkg::OFS_COMPARE_A, l + 8'h02);
        wr(tcc_pkg::OFS_COUNTER_HIGH, ~h);
        rd(tcc_pkg::OFS_COMPARE_B);
        chk(r, h, "compare high read bypasses holder");
        clear_flags();
        // First tick drains the match left pending by the clear-on-match test
        ticks(1);
        clear_flags();
        ticks(3);
        chk(flags, 4'b1000, "16-bit compare flag");
        // Capture on each edge polarity, wrong edge first
        wr(tcc_pkg::OFS_CONTROL_A, 8'h00);
        c = rnd();
        wr(tcc_pkg::OFS_COUNTER_LOW, c);
        for (int e = 0; e < 2; e++) begin
            @(posedge ref_clk_i) pin <= e[0];
            wr(tcc_pkg::OFS_CONTROL_A, {3'b010, e[0], 4'h0});
            cyc(12);
            clear_flags();
            @(posedge ref_clk_i) pin <= ~e[0];
            cyc(12);
            chk(flags, 4'b0000, "wrong edge ignored");
            @(posedge ref_clk_i) pin <= e[0];
            cyc(12);
            chk(flags, 4'b0001, "capture flag");
            rd(tcc_pkg::OFS_COMPARE_A);
            chk(r, c, "captured count");
        end
        // Filter: a short glitch is dropped and a real edge arrives late
        wr(tcc_pkg::OFS_CONTROL_A, 8'h70);
        @(posedge ref_clk_i) pin <= 1'b0;
        cyc(15);
        clear_flags();
        @(posedge ref_clk_i) pin <= 1'b1;
        cyc(2);
        pin <= 1'b0;
        cyc(15);
        chk(flags, 4'b0000, "glitch filtered");
        pin <= 1'b1;
        cyc(5);
        #1 chk(flags, 4'b0000, "filter delay");
        cyc(10);
        chk(flags, 4'b0001, "filtered capture");
        // Comparator as capture source, then disconnected
        @(posedge ref_clk_i) pin <= 1'b0;
        wr(tcc_pkg::OFS_CONTROL_A, 8'h58);
        cyc(12);
        clear_flags();
        @(posedge ref_clk_i) pin <= 1'b1;
        cyc(12);
        chk(flags, 4'b0000, "pin ignored when routed");
        @(posedge ref_clk_i) comp <= 1'b1;
        cyc(12);
        chk(flags, 4'b0001, "comparator capture");
        chk(irq, 4'b0001, "capture request");
        wr(tcc_pkg::OFS_CONTROL_A, 8'h50);
        cyc(12);
        clear_flags();
        @(posedge ref_clk_i) comp <= 1'b0;
        cyc(6);
        comp <= 1'b1;
        cyc(12);
        chk(flags, 4'b0000, "comparator disconnected");
        // Wide capture: both compare bytes take the count, high byte comes back through the holder
        wr(tcc_pkg::OFS_CONTROL_A, 8'hD0);
        @(posedge ref_clk_i) pin <= 1'b0;
        cyc(12);
        @(posedge ref_clk_i) pin <= 1'b1;
        cyc(12);
        u_tcc_cpu_model.rd16(tcc_pkg::OFS_COMPARE_B, tcc_pkg::OFS_COMPARE_A, v);
        chk(v, {h, c}, "16-bit capture read");
        print_verdict();
    end
endmodule
`default_nettype wire
